// ==== rtl/mcuifd_pkg.sv ====
// Shared constants, register map and types for the instruction format decoder
package mcuifd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle framing
  localparam int unsigned OSC_PER_ICYC = 4;
  localparam logic [1:0] QPH_RESET = 2'h0;
  localparam logic [1:0] QPH_LAST = 2'(OSC_PER_ICYC - 1);

  // Instruction set sizes
  localparam int unsigned STD_INSN_COUNT = 75;
  localparam int unsigned EXT_INSN_COUNT = 8;

  // Word layout
  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] DW_TAIL_TOP = 4'hf;
  localparam logic [15:0] FLUSH_WORD = 16'hf000;
  localparam int unsigned D_BIT = 9;
  localparam int unsigned A_BIT = 8;
  localparam int unsigned BIT_LSB = 9;
  localparam int unsigned PTR_LSB = 4;
  localparam int unsigned FAST_BIT = 0;
  localparam int unsigned TMODE_LSB = 0;

  // Access RAM split between the low and the high bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // Program counter and table pointer
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] TABLE_PTR_RESET = 21'h000000;
  localparam logic [20:0] TBL_STEP = 21'h000001;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TABLE_PTR = 12'h008;
  localparam logic [11:0] REG_PC = 12'h00c;
  localparam logic [11:0] REG_INSN = 12'h010;
  localparam logic [11:0] REG_CYCLES = 12'h014;
  localparam logic [11:0] REG_NOPS = 12'h018;
  localparam logic [11:0] REG_DECODE = 12'h01c;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam int unsigned STAT_REJ_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    CLS_NOP = 3'h0,
    CLS_BYTE = 3'h1,
    CLS_LIT = 3'h2,
    CLS_BIT = 3'h3,
    CLS_EXT = 3'h4,
    CLS_DW = 3'h5,
    CLS_CTRL = 3'h6,
    CLS_TABLE = 3'h7
  } mcuifd_class_type;

  typedef enum logic [1:0] {
    TM_KEEP = 2'h0,
    TM_POSTINC = 2'h1,
    TM_POSTDEC = 2'h2,
    TM_PREINC = 2'h3
  } mcuifd_tmode_type;

  typedef enum logic [1:0] {
    SEQ_SINGLE = 2'b00,
    SEQ_DW_HEAD = 2'b01,
    SEQ_DW_TAIL = 2'b11,
    SEQ_FLUSH = 2'b10
  } mcuifd_seq_type;

  // Opcode class patterns, first match wins; anything else is byte-oriented
  localparam int NPAT = 15;
  localparam logic [15:0] PAT_MASK [NPAT] = '{
    16'hf000, 16'hf000, 16'hff00, 16'hfe00, 16'hffc0, 16'hfc00, 16'hfff8, 16'hfffc,
    16'hf800, 16'he000, 16'hf000, 16'hf000, 16'hf800, 16'hffff, 16'hff00};
  localparam logic [15:0] PAT_MATCH [NPAT] = '{
    16'hf000, 16'hc000, 16'hef00, 16'hec00, 16'hee00, 16'he800, 16'h0008, 16'h0010,
    16'h0800, 16'h8000, 16'h7000, 16'hd000, 16'he000, 16'h0000, 16'h0000};
  localparam mcuifd_class_type PAT_CLASS [NPAT] = '{
    CLS_NOP, CLS_DW, CLS_DW, CLS_DW, CLS_DW, CLS_EXT, CLS_TABLE, CLS_CTRL,
    CLS_LIT, CLS_BIT, CLS_BIT, CLS_CTRL, CLS_CTRL, CLS_NOP, CLS_CTRL};

endpackage

// ==== rtl/mcuifd_qphase.sv ====
// Oscillator phase counter that frames each instruction cycle
`timescale 1ns/100ps
module mcuifd_qphase
  import mcuifd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic [1:0] qphase,
  output logic cyc_end
);

  logic [1:0] qph_q;

  // Phase only advances while running, so a halted core keeps its place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qph_q <= QPH_RESET;
    end else if (run) begin
      qph_q <= (qph_q == QPH_LAST) ? QPH_RESET : qph_q + 2'h1;
    end
  end

  assign qphase = qph_q;
  assign cyc_end = run && (qph_q == QPH_LAST);

endmodule

// ==== rtl/mcuifd_decoder.sv ====
// Instruction fetch framing, operand field decode and cycle accounting
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
//
// Operation
// - An ordinary instruction is one 16-bit word of opcode plus operand fields.
// - Four instructions span two consecutive words, 32 bits in all.
// - A second word has its top four bits set and runs as a no-op alone.
// - A single-word instruction takes one cycle, or two with a no-op when a test is true or the PC changes.
// - A double-word instruction always takes two instruction cycles.
// - One instruction cycle is four oscillator periods.
// - Destination bit 0 sends the result to the working register, 1 to the file register.
// - Access bit 0 uses access RAM and ignores the bank select register, 1 uses that register.
// - A three-bit field picks bit 0 to 7 of the addressed byte.
// - The file field is an 8-bit address or, for pointer loads, a 2-bit pointer select.
// - Register moves carry separate 12-bit source and destination addresses.
// - The decoder knows a standard set of 75 and an extended set of 8 instructions.
// - Five arithmetic flags are kept: carry, half carry, zero, overflow, negative.
// - Call and return carry a fast bit that selects the shadow register save or restore.
// - Table operations apply keep, post-increment, post-decrement or pre-increment to the table pointer.
//
module mcuifd_decoder
  import mcuifd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic [20:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire logic [3:0] bank_select_register,
  input wire logic exec_skip,
  input wire logic exec_pc_load,
  input wire logic [20:0] exec_pc_target,
  input wire logic alu_flags_we,
  input wire logic [4:0] alu_flags_in,
  output logic [1:0] qphase,
  output logic icyc_end,
  output mcuifd_class_type dec_class,
  output logic dec_exec,
  output logic dec_dw_wait,
  output logic dec_dest_file,
  output logic dec_wr_working,
  output logic dec_access_ram,
  output logic [11:0] dec_file_addr,
  output logic [2:0] dec_bit_index,
  output logic [7:0] dec_bit_mask,
  output logic [1:0] dec_ptr_sel,
  output logic [11:0] dec_src_addr,
  output logic [11:0] dec_dst_addr,
  output logic dec_fast,
  output mcuifd_tmode_type dec_tbl_mode,
  output logic [20:0] table_pointer,
  output logic [20:0] tbl_addr,
  output logic [4:0] status_flags
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [1:0] ctrl_q;
  logic run_q;
  logic ext_en_q;
  logic ext_rej_q;
  logic [20:0] pc_q;
  logic [15:0] head_q;
  logic [15:0] tail_q;
  logic [31:0] cycles_q;
  logic [31:0] nops_q;
  logic [31:0] prdata_q;
  mcuifd_seq_type seq_q;
  mcuifd_seq_type seq_d;
  logic flush;
  logic [15:0] next_word;
  mcuifd_class_type raw_cls;
  mcuifd_class_type next_cls;
  mcuifd_tmode_type tmode_d;
  logic [11:0] file_addr_d;
  logic apb_wr;
  logic addr_hit;
  logic [31:0] rd_mux;

  assign run_q = ctrl_q[CTRL_RUN_BIT];
  assign ext_en_q = ctrl_q[CTRL_EXT_BIT];

  mcuifd_qphase u_qphase (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_q),
    .qphase(qphase),
    .cyc_end(icyc_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Class lookup over the opcode pattern table; lowest index wins
  function automatic mcuifd_class_type classify(input logic [15:0] w);
    mcuifd_class_type c;
    c = CLS_BYTE;
    for (int i = NPAT - 1; i >= 0; i--) begin
      if ((w & PAT_MASK[i]) == PAT_MATCH[i]) begin
        c = PAT_CLASS[i];
      end
    end
    return c;
  endfunction

  // Word entering execution at the next cycle boundary
  always_comb begin
    flush = exec_skip || exec_pc_load;
    next_word = flush ? FLUSH_WORD : pm_rdata;
    raw_cls = classify(next_word);
    next_cls = raw_cls;
    if (raw_cls == CLS_EXT && !ext_en_q) begin
      next_cls = CLS_NOP;
    end
    tmode_d = mcuifd_tmode_type'(next_word[TMODE_LSB +: 2]);
    if (next_word[A_BIT]) begin
      file_addr_d = {bank_select_register, next_word[7:0]};
    end else begin
      file_addr_d = {(next_word[7:0] >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, next_word[7:0]};
    end
  end

  // A lone tail word never follows a head, so it classes as a no-op
  always_comb begin
    case (seq_q)
      SEQ_DW_HEAD: seq_d = flush ? SEQ_FLUSH : SEQ_DW_TAIL;
      SEQ_SINGLE, SEQ_DW_TAIL, SEQ_FLUSH: begin
        if (flush) begin
          seq_d = SEQ_FLUSH;
        end else if (next_cls == CLS_DW) begin
          seq_d = SEQ_DW_HEAD;
        end else begin
          seq_d = SEQ_SINGLE;
        end
      end
      default: seq_d = SEQ_SINGLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= SEQ_SINGLE;
    end else if (icyc_end) begin
      seq_q <= seq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch: the word at pm_addr is taken at the last phase of each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RESET;
    end else if (icyc_end) begin
      pc_q <= exec_pc_load ? exec_pc_target : pc_q + PC_STEP;
    end
  end

  assign pm_addr = pc_q;

  // Operand fields are latched once per cycle and held for its four phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_class <= CLS_NOP;
      dec_exec <= 1'b0;
      dec_dw_wait <= 1'b0;
      dec_dest_file <= 1'b0;
      dec_wr_working <= 1'b1;
      dec_access_ram <= 1'b1;
      dec_file_addr <= 12'h000;
      dec_bit_index <= 3'h0;
      dec_bit_mask <= 8'h01;
      dec_ptr_sel <= 2'h0;
      dec_src_addr <= 12'h000;
      dec_dst_addr <= 12'h000;
      dec_fast <= 1'b0;
      dec_tbl_mode <= TM_KEEP;
      head_q <= FLUSH_WORD;
      tail_q <= FLUSH_WORD;
    end else if (icyc_end) begin
      if (seq_d == SEQ_DW_TAIL) begin
        dec_dst_addr <= next_word[11:0];
        dec_exec <= 1'b1;
        dec_dw_wait <= 1'b0;
        tail_q <= next_word;
      end else begin
        dec_class <= next_cls;
        dec_exec <= (seq_d == SEQ_SINGLE) && (next_cls != CLS_NOP);
        dec_dw_wait <= (seq_d == SEQ_DW_HEAD);
        dec_dest_file <= next_word[D_BIT];
        dec_wr_working <= !next_word[D_BIT];
        dec_access_ram <= !next_word[A_BIT];
        dec_file_addr <= file_addr_d;
        dec_bit_index <= next_word[BIT_LSB +: 3];
        dec_bit_mask <= 8'h01 << next_word[BIT_LSB +: 3];
        dec_ptr_sel <= next_word[PTR_LSB +: 2];
        dec_src_addr <= next_word[11:0];
        dec_fast <= next_word[FAST_BIT];
        dec_tbl_mode <= tmode_d;
        head_q <= next_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table pointer; the hardware step wins over a same-cycle bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer <= TABLE_PTR_RESET;
      tbl_addr <= TABLE_PTR_RESET;
    end else if (icyc_end && seq_d == SEQ_SINGLE && next_cls == CLS_TABLE) begin
      case (tmode_d)
        TM_POSTINC: begin
          tbl_addr <= table_pointer;
          table_pointer <= table_pointer + TBL_STEP;
        end
        TM_POSTDEC: begin
          tbl_addr <= table_pointer;
          table_pointer <= table_pointer - TBL_STEP;
        end
        TM_PREINC: begin
          tbl_addr <= table_pointer + TBL_STEP;
          table_pointer <= table_pointer + TBL_STEP;
        end
        default: tbl_addr <= table_pointer;
      endcase
    end else if (apb_wr && paddr == REG_TABLE_PTR) begin
      table_pointer <= pwdata[20:0];
    end
  end

  // Flags follow the arithmetic unit; a bus write only lands when it is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags <= FLAGS_RESET;
    end else if (alu_flags_we) begin
      status_flags <= alu_flags_in;
    end else if (apb_wr && paddr == REG_STATUS) begin
      status_flags <= pwdata[4:0];
    end
  end

  // Sticky reject of extended opcodes; a new reject beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_rej_q <= 1'b0;
    end else if (icyc_end && !flush && raw_cls == CLS_EXT && !ext_en_q) begin
      ext_rej_q <= 1'b1;
    end else if (apb_wr && paddr == REG_STATUS && pwdata[STAT_REJ_BIT]) begin
      ext_rej_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles_q <= 32'h00000000;
      nops_q <= 32'h00000000;
    end else if (icyc_end) begin
      cycles_q <= cycles_q + 32'h00000001;
      if (seq_d == SEQ_FLUSH) begin
        nops_q <= nops_q + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait, read data captured in the setup cycle
  assign apb_wr = psel && penable && pwrite && addr_hit;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      REG_CTRL: rd_mux = {30'h00000000, ctrl_q};
      REG_STATUS: rd_mux = {23'h000000, ext_rej_q, 3'h0, status_flags};
      REG_TABLE_PTR: rd_mux = {11'h000, table_pointer};
      REG_PC: rd_mux = {11'h000, pc_q};
      REG_INSN: rd_mux = {tail_q, head_q};
      REG_CYCLES: rd_mux = cycles_q;
      REG_NOPS: rd_mux = nops_q;
      REG_DECODE: rd_mux = {12'h000, dec_bit_index, dec_exec, dec_dw_wait, dec_class, dec_file_addr};
      default: begin
        rd_mux = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && paddr == REG_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_dw_head_in;
    icyc_end && !flush && seq_q != SEQ_DW_HEAD && next_cls == CLS_DW;
  endsequence

  sequence s_dw_head_hold;
    (dec_dw_wait && !(icyc_end && flush)) [*4];
  endsequence

  property p_dw_two_cycles;
    @(posedge pclk) disable iff (!presetn || !run_q)
      s_dw_head_in ##1 s_dw_head_hold |=> dec_exec && !dec_dw_wait && dec_class == CLS_DW;
  endproperty
  a_dw_two_cycles: assert property (p_dw_two_cycles) else $error("double word did not finish in two cycles");

  property p_icyc_four;
    @(posedge pclk) disable iff (!presetn || !run_q)
      icyc_end |=> (!icyc_end) [*3] ##1 icyc_end;
  endproperty
  a_icyc_four: assert property (p_icyc_four) else $error("instruction cycle not four clocks");

  property p_flush_nop;
    icyc_end && flush |=> dec_class == CLS_NOP && !dec_exec && !dec_dw_wait;
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("forced cycle did not decode as no-op");

  property p_tail_alone;
    icyc_end && !flush && seq_q != SEQ_DW_HEAD && pm_rdata[15:12] == DW_TAIL_TOP |=> dec_class == CLS_NOP && !dec_exec;
  endproperty
  a_tail_alone: assert property (p_tail_alone) else $error("lone second word did not act as no-op");

  property p_dest;
    icyc_end && seq_d != SEQ_DW_TAIL |=> dec_dest_file == $past(next_word[D_BIT]) && dec_wr_working != dec_dest_file;
  endproperty
  a_dest: assert property (p_dest) else $error("destination select mismatch");

  property p_bank;
    icyc_end && seq_d != SEQ_DW_TAIL && next_word[A_BIT] |=>
      dec_file_addr[11:8] == $past(bank_select_register) && !dec_access_ram;
  endproperty
  a_bank: assert property (p_bank) else $error("banked address not taken from bank select");

  property p_bit_sel;
    icyc_end && seq_d != SEQ_DW_TAIL |=>
      dec_bit_index == $past(next_word[11:9]) && $onehot(dec_bit_mask) && dec_bit_mask[dec_bit_index];
  endproperty
  a_bit_sel: assert property (p_bit_sel) else $error("bit select does not match field");

  property p_move_addr;
    icyc_end && seq_q == SEQ_DW_HEAD && !flush |=>
      dec_dst_addr == $past(pm_rdata[11:0]) && dec_src_addr == head_q[11:0];
  endproperty
  a_move_addr: assert property (p_move_addr) else $error("move source or destination wrong");

  property p_tbl_preinc;
    icyc_end && seq_d == SEQ_SINGLE && next_cls == CLS_TABLE && tmode_d == TM_PREINC |=>
      table_pointer == $past(table_pointer) + TBL_STEP && tbl_addr == table_pointer;
  endproperty
  a_tbl_preinc: assert property (p_tbl_preinc) else $error("pre-increment table access wrong");

  property p_flags;
    alu_flags_we |=> status_flags == $past(alu_flags_in);
  endproperty
  a_flags: assert property (p_flags) else $error("status flags not loaded");

endmodule

// ==== bench/mcuifd_pmem_model.sv ====
// Program memory model that answers the decoder's fetch address
`timescale 1ns/100ps
module mcuifd_pmem_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [20:0] pm_addr,
  output logic [15:0] pm_rdata
);
  logic [15:0] mem [64];
  logic [20:0] addr_q;

  always_ff @(posedge pclk) begin
    addr_q <= pm_addr;
  end

  // Whole 16-bit words at even byte addresses, a double word sits in two neighbours
  // Slow mode shows a wrong word for the first clock after the address moves
  always_comb begin
    if (slow && addr_q != pm_addr) begin
      pm_rdata = ~mem[pm_addr[6:1]];
    end else begin
      pm_rdata = mem[pm_addr[6:1]];
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the instruction format decoder
`timescale 1ns/100ps
module tb_top
  import mcuifd_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic exec_skip, exec_pc_load, alu_flags_we, icyc_end, dec_exec, dec_dw_wait;
  logic dec_dest_file, dec_wr_working, dec_access_ram, dec_fast;
  logic [11:0] paddr, dec_file_addr, dec_src_addr, dec_dst_addr;
  logic [31:0] pwdata, prdata;
  logic [20:0] pm_addr, exec_pc_target, table_pointer, tbl_addr;
  logic [15:0] pm_rdata;
  logic [15:0] prog [29];
  logic [3:0] bank_select_register, bsr_cap;
  logic [4:0] alu_flags_in, status_flags;
  logic [2:0] dec_bit_index;
  logic [7:0] dec_bit_mask;
  logic [1:0] dec_ptr_sel, qphase;
  mcuifd_class_type dec_class;
  mcuifd_tmode_type dec_tbl_mode;
  int err_total = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int gap_n = 0;

  mcuifd_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .pm_addr, .pm_rdata, .bank_select_register, .exec_skip, .exec_pc_load, .exec_pc_target,
    .alu_flags_we, .alu_flags_in, .qphase, .icyc_end, .dec_class, .dec_exec, .dec_dw_wait, .dec_dest_file,
    .dec_wr_working, .dec_access_ram, .dec_file_addr, .dec_bit_index, .dec_bit_mask, .dec_ptr_sel,
    .dec_src_addr, .dec_dst_addr, .dec_fast, .dec_tbl_mode, .table_pointer, .tbl_addr, .status_flags);
  mcuifd_pmem_model pm (.pclk, .slow, .pm_addr, .pm_rdata);

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] ad, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, ad, 32'h0, rd, er);
    chk(nm, e, rd);
    chk("pslverr", 32'(ee), 32'(er));
  endtask

  // Waits for a cycle end, captures the word that enters decode and drives the next cycle's inputs
  task automatic step(input logic sk, input logic ld, output logic [15:0] w, output logic [20:0] a);
    logic [20:0] nx;
    int n;
    n = 0;
    @(negedge pclk);
    while (icyc_end !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    w = pm_rdata;
    a = pm_addr;
    bsr_cap = bank_select_register;
    nx = exec_pc_load ? exec_pc_target : a + 21'h2;
    @(posedge pclk);
    exec_skip <= sk;
    exec_pc_load <= ld;
    bank_select_register <= 4'($urandom);
    @(negedge pclk);
    chk("pm_addr", 32'(nx), 32'(pm_addr));
    chk("qphase", 32'(QPH_RESET), 32'(qphase));
  endtask

  task automatic byte_chk(input logic [15:0] w);
    logic [3:0] bk;
    bk = w[8] ? bsr_cap : ((w[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK);
    chk("class", 32'(CLS_BYTE), 32'(dec_class));
    chk("exec", 32'h1, 32'(dec_exec));
    chk("dest_file", 32'(w[9]), 32'(dec_dest_file));
    chk("wr_working", 32'(!w[9]), 32'(dec_wr_working));
    chk("access_ram", 32'(!w[8]), 32'(dec_access_ram));
    chk("file_addr", 32'({bk, w[7:0]}), 32'(dec_file_addr));
  endtask

  function automatic logic [15:0] mkword(input int k);
    logic [15:0] r;
    r = 16'($urandom);
    case (k)
      6, 7, 8: return {4'h7, r[11:0]};
      9: return {3'h4, r[12:0]};
      10, 23: return {4'hc, r[11:0]};
      11, 12, 24: return {4'hf, r[11:0]};
      13, 14, 15, 16: return 16'(k - 5);
      17: return 16'h0011;
      18: return {5'h01, r[10:0]};
      19: return {6'h3a, r[9:0]};
      default: return 16'h1000 + (r % 16'h6000);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle ends must come every fourth clock
  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      err_total++;
      print_verdict();
    end
    if (presetn && icyc_end === 1'b1) begin
      if (gap_n != 0) chk("icyc_gap", 32'd4, 32'(gap_n));
      gap_n <= 1;
    end else if (gap_n != 0) begin
      gap_n <= gap_n + 1;
    end
  end

  initial begin
    logic [31:0] rd;
    logic er;
    logic [15:0] w;
    logic [20:0] a;
    logic [20:0] tp;
    logic [4:0] fv;
    int k;
    void'($urandom(12657));
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, exec_skip, exec_pc_load, alu_flags_we, slow} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bank_select_register = 4'h5;
    alu_flags_in = 5'h00;
    exec_pc_target = 21'h000058;
    for (k = 0; k < 64; k++) pm.mem[k] = 16'h0000;
    // Test words start at index 16 so register traffic finishes before they are fetched
    for (k = 0; k < 29; k++) begin
      prog[k] = mkword(k);
      pm.mem[16 + k] = prog[k];
    end
    pm.mem[50] = mkword(19);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl", REG_CTRL, 32'h3, 1'b0);
    rd_chk("status", REG_STATUS, 32'h0, 1'b0);
    rd_chk("table_ptr", REG_TABLE_PTR, 32'h0, 1'b0);
    apb(1'b1, 12'h020, 32'h1, rd, er);
    chk("unmapped_err", 32'h1, 32'(er));
    rd_chk("unmapped", 12'h020, 32'h0, 1'b1);
    apb(1'b1, REG_TABLE_PTR, 32'h100, rd, er);
    rd_chk("table_ptr", REG_TABLE_PTR, 32'h100, 1'b0);
    tp = 21'h100;
    step(1'b0, 1'b0, w, a);
    while (a !== 21'h20 && cyc_cnt < 2000) step(1'b0, 1'b0, w, a);
    for (k = 0; k < 27; k++) begin
      if (k > 0) step(k == 20 || k == 22, k == 25, w, a);
      case (k)
        6, 7, 8, 9: begin
          chk("class", 32'(CLS_BIT), 32'(dec_class));
          chk("bit_index", 32'(w[11:9]), 32'(dec_bit_index));
          chk("bit_mask", {24'h0, 8'h01 << w[11:9]}, 32'(dec_bit_mask));
        end
        10: begin
          chk("class", 32'(CLS_DW), 32'(dec_class));
          chk("dw_wait", 32'h1, 32'(dec_dw_wait));
          chk("src_addr", 32'(w[11:0]), 32'(dec_src_addr));
        end
        11: begin
          chk("class", 32'(CLS_DW), 32'(dec_class));
          chk("exec", 32'h1, 32'(dec_exec));
          chk("dst_addr", 32'(w[11:0]), 32'(dec_dst_addr));
        end
        12, 21, 23, 24, 26: chk("class", 32'(CLS_NOP), 32'(dec_class));
        13, 14, 15, 16: begin
          if (k == 16) tp = tp + 21'h1;
          chk("tbl_addr", 32'(tp), 32'(tbl_addr));
          if (k == 14) tp = tp + 21'h1;
          if (k == 15) tp = tp - 21'h1;
          chk("table_pointer", 32'(tp), 32'(table_pointer));
          chk("tbl_mode", 32'(k - 13), 32'(dec_tbl_mode));
        end
        17: chk("fast", 32'h1, 32'(dec_fast));
        18: chk("ptr_sel", 32'(w[5:4]), 32'(dec_ptr_sel));
        19: chk("class", 32'(CLS_EXT), 32'(dec_class));
        default: byte_chk(w);
      endcase
    end
    @(posedge pclk);
    slow <= 1'b1;
    step(1'b0, 1'b0, w, a);
    chk("jump_word", 32'(prog[28]), 32'(w));
    byte_chk(w);
    apb(1'b1, REG_CTRL, 32'h1, rd, er);
    step(1'b0, 1'b0, w, a);
    while (a !== 21'h64 && cyc_cnt < 2000) step(1'b0, 1'b0, w, a);
    chk("class", 32'(CLS_NOP), 32'(dec_class));
    rd_chk("status", REG_STATUS, 32'h100, 1'b0);
    apb(1'b1, REG_STATUS, 32'h100, rd, er);
    rd_chk("status", REG_STATUS, 32'h0, 1'b0);
    fv = 5'($urandom) | 5'h01;
    @(posedge pclk);
    alu_flags_we <= 1'b1;
    alu_flags_in <= fv;
    @(posedge pclk);
    alu_flags_we <= 1'b0;
    @(negedge pclk);
    chk("status_flags", 32'(fv), 32'(status_flags));
    rd_chk("status", REG_STATUS, {27'h0, fv}, 1'b0);
    // Three forced no-op cycles: two skips and one jump
    rd_chk("nops", REG_NOPS, 32'h3, 1'b0);
    print_verdict();
  end
endmodule
